// *** dss_clkdiv.sv ***
`timescale 1ns/1ps
module dss_clkdiv (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_n,
   // control
   input  wire logic en,
   // link clock
   output logic      clk_o,
   output logic      upd
);

   typedef struct packed {
      logic [7:0] cnt;
      logic       lvl;
   } dss_div_t;

   dss_div_t s_q;
   dss_div_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (!en)
      begin
         s_d = '0;
      end
      else if (s_q.cnt == dss_pkg::DCLK_HALF_CYC - 8'h01)
      begin
         s_d.cnt = '0;
         s_d.lvl = !s_q.lvl;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign clk_o = s_q.lvl;
   // new data is launched as the clock falls, half a period ahead of its rising edge
   assign upd   = en && s_q.lvl && (s_q.cnt == dss_pkg::DCLK_HALF_CYC - 8'h01);

endmodule

// *** dss_dev_model.sv ***
`timescale 1ns/1ps
module dss_dev_model #(
   parameter int LOCK_DCLKS = 40
) (
   // device pins
   input wire logic         reset_n_pin,
   input wire logic         lvds_data_clock,
   input wire logic         lvds_sync_input,
   input wire logic [15:0]  lvds_data,
   // serial pins
   input wire logic         sif_sclk,
   input wire logic         sif_sden_n,
   input wire logic         sif_sdio_o,
   output logic             serial_out_pin,
   // observation
   output logic             passing,
   output logic [15:0]      sample
);
   // ****************
   // serial registers and loop
   // ****************
   logic [7:0]  regs [0:127];
   logic [15:0] shft;
   logic [7:0]  rd_buf;
   logic        rd_q, armed, rel_ok;
   int          nbit, dclks, lock_cnt, polls;
   wire         lock = lock_cnt == LOCK_DCLKS;
   wire         src = regs[3][1] ? regs[3][0] : lvds_sync_input;
   assign passing = reset_n_pin && src;
   task automatic clear;
      foreach (regs[i]) regs[i] = 8'h00;
      {armed, rel_ok, rd_q, serial_out_pin} = 4'h0;
      {dclks, lock_cnt, polls} = 0;
   endtask
   initial clear();
   always @(negedge reset_n_pin) clear();
   always @(negedge sif_sden_n) {nbit, rd_q} = 0;
   // a released line must not keep its last level
   always @(posedge sif_sden_n) serial_out_pin = ~serial_out_pin;
   always @(negedge sif_sclk)
      serial_out_pin = (rd_q && nbit < 16) ? rd_buf[15 - nbit] : ~serial_out_pin;
   always @(posedge sif_sclk)
      if (!sif_sden_n)
      begin
         shft = {shft[14:0], sif_sdio_o};
         nbit++;
         if (nbit == 8 && shft[7])
         begin
            rd_q = 1'h1;
            rd_buf = shft[6:0] == 7'h00 ? {7'h00, lock} : regs[shft[6:0]];
            polls += int'(shft[6:0] == 7'h00);
         end
         if (nbit == 16 && !shft[15])
         begin
            regs[shft[14:8]] = shft[7:0];
            if (shft[14:8] == 7'h0A && shft[7])
               armed = 1'h1;
            if (shft[14:8] == 7'h0A && !shft[7] && armed)
               rel_ok = dclks > 8;
         end
      end
   // lock only builds while the restart bit is clear
   always @(posedge lvds_data_clock)
   begin
      dclks++;
      lock_cnt = (regs[10][7] || !armed) ? 0 : (lock ? lock_cnt : lock_cnt + 1);
      if (passing)
         sample = lvds_data;
   end
endmodule

// *** dss_host.sv ***
//
// Overview of operation
// RL1 - after clocks settle, drive device reset low for at least 25 ns
// RL2 - after reset write all config registers, with loop restart bit set
// RL3 - write data clock range register matching the supplied data clock band
// RL4 - data clock runs and is stable before restart bit is released
// RL5 - clear restart bit only after the data clock has settled
// RL6 - read lock flag repeatedly; proceed only once it reads one
// RL7 - device shows lock in status register and on serial out pin
// RL8 - enable data by sync pin or software sync bit, per select bit
// RL9 - data flows only while chosen sync source is held at one
// RL10 - after sync, stream sixteen-bit samples timed by the data clock
// RL11 - with pin sync, first sample may coincide with sync rising
// RL12 - signal done only after lock and sync; keep data idle before
//
`timescale 1ns/1ps
module dss_host #(
   parameter logic [15:0] DCLK_SETTLE_CYC = 16'h0100,
   parameter logic [15:0] POLL_GAP_CYC    = 16'h0040
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // software register port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata,
   output logic             irq,
   // device control pins
   output logic             reset_n_pin,
   output logic             lvds_data_clock,
   output logic             lvds_sync_input,
   output logic [15:0]      lvds_data,
   // serial register interface
   output logic             sif_sclk,
   output logic             sif_sden_n,
   output logic             sif_sdio_o,
   output logic             sif_sdio_oe,
   input  wire logic        sif_sdio_i
);

   // ***********************************************************
   // state
   // ***********************************************************
   typedef struct packed {
      dss_pkg::dss_state_t         st;
      logic                        sent;
      logic [15:0]                 cnt;
      logic                        start;
      logic                        software_sync_bit;
      logic                        run;
      logic [7:0]                  range;
      logic [7:0]                  sync_cfg;
      logic [15:0]                 sample;
      logic [dss_pkg::IRQ_W-1:0]   irq_stat;
      logic [dss_pkg::IRQ_W-1:0]   irq_mask;
      logic                        locked;
      logic                        done;
      logic                        use_sw;
      logic                        rst_pin;
      logic                        sync_pin;
      logic [15:0]                 data;
      logic [31:0]                 rdata;
   } dss_host_t;

   dss_host_t              s_q;
   dss_host_t              s_d;
   dss_pkg::dss_sif_req_t  sif_req;
   dss_pkg::dss_sif_rsp_t  sif_rsp;
   dss_pkg::dss_sif_pins_t sif_pins;
   logic                   dclk_en;
   logic                   dclk_upd;

   // ***********************************************************
   // helpers
   // ***********************************************************
   dss_sif u_sif (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .req    (sif_req),
      .rsp    (sif_rsp),
      .pins   (sif_pins),
      .sdio_i (sif_sdio_i)
   );

   // clock keeps running from programming onward so it is stable well before release
   assign dclk_en = (s_q.st != dss_pkg::ST_IDLE) && (s_q.st != dss_pkg::ST_RST_LOW) &&
                    (s_q.st != dss_pkg::ST_RST_WAIT); // RL4

   dss_clkdiv u_div (
      .mclk  (mclk),
      .rst_n (rst_n),
      .en    (dclk_en),
      .clk_o (lvds_data_clock),
      .upd   (dclk_upd)
   );

   // ***********************************************************
   // sequencer and registers
   // ***********************************************************
   logic                      want;
   logic                      want_rd;
   logic [6:0]                want_addr;
   logic [7:0]                want_data;
   dss_pkg::dss_state_t       want_nxt;
   logic [dss_pkg::IRQ_W-1:0] ev;
   logic [7:0]                sync_wr;

   always_comb
   begin
      s_d       = s_q;
      s_d.start = 1'b0;
      want      = 1'b0;
      want_rd   = 1'b0;
      want_addr = '0;
      want_data = '0;
      want_nxt  = s_q.st;
      ev        = '0;
      sif_req   = '0;
      sync_wr   = s_q.sync_cfg;
      sync_wr[dss_pkg::SYNC_SEL_BIT] = s_q.use_sw; // RL8

      // software writes
      if (wr)
      begin
         case (addr)
            dss_pkg::REG_CTRL:
            begin
               s_d.start   = wdata[dss_pkg::CTRL_START];
               s_d.software_sync_bit = wdata[dss_pkg::CTRL_SOFTWARE_SYNC_BIT];
               s_d.run     = wdata[dss_pkg::CTRL_RUN];
            end
            dss_pkg::REG_RANGE:    s_d.range    = wdata[7:0];
            dss_pkg::REG_IRQ_MASK: s_d.irq_mask = wdata[dss_pkg::IRQ_W-1:0];
            dss_pkg::REG_SAMPLE:   s_d.sample   = wdata[15:0];
            dss_pkg::REG_SYNC_CFG: s_d.sync_cfg = wdata[7:0];
            default:               s_d.sent     = s_q.sent;
         endcase
      end

      case (s_q.st)
         dss_pkg::ST_IDLE:
         begin
            if (s_q.start)
            begin
               s_d.st      = dss_pkg::ST_RST_LOW;
               s_d.cnt     = '0;
               s_d.rst_pin = 1'b0;
               s_d.locked  = 1'b0;
               s_d.done    = 1'b0;
               s_d.use_sw  = s_q.software_sync_bit;
            end
         end
         dss_pkg::ST_RST_LOW:
         begin
            s_d.cnt = s_q.cnt + 16'h0001;
            if (s_q.cnt == {8'h00, dss_pkg::RST_LOW_CYC} - 16'h0001)
            begin
               s_d.rst_pin = 1'b1; // RL1
               s_d.cnt     = '0;
               s_d.st      = dss_pkg::ST_RST_WAIT;
            end
         end
         dss_pkg::ST_RST_WAIT:
         begin
            s_d.cnt = s_q.cnt + 16'h0001;
            if (s_q.cnt == {8'h00, dss_pkg::RST_RECOVER_CYC})
               s_d.st = dss_pkg::ST_WR_RANGE;
         end
         dss_pkg::ST_WR_RANGE:
         begin
            want      = 1'b1;
            want_addr = dss_pkg::ADDR_DCLK_RANGE; // RL3
            want_data = s_q.range;
            want_data[dss_pkg::RESTART_BIT] = 1'b1; // RL2
            want_nxt  = dss_pkg::ST_WR_SOUT;
         end
         dss_pkg::ST_WR_SOUT:
         begin
            want      = 1'b1;
            want_addr = dss_pkg::ADDR_SOUT_CFG; // RL7
            want_data = dss_pkg::SOUT_FUNC_LOCK;
            want_nxt  = dss_pkg::ST_WR_SYNC;
         end
         dss_pkg::ST_WR_SYNC:
         begin
            want      = 1'b1;
            want_addr = dss_pkg::ADDR_SYNC_CFG; // RL2
            want_data = sync_wr;
            want_data[dss_pkg::SOFTWARE_SYNC_BIT_BIT] = 1'b0;
            want_nxt  = dss_pkg::ST_DCLK_SETTLE;
         end
         dss_pkg::ST_DCLK_SETTLE:
         begin
            s_d.cnt = s_q.cnt + 16'h0001;
            if (s_q.cnt == DCLK_SETTLE_CYC)
               s_d.st = dss_pkg::ST_WR_RELEASE; // RL5
         end
         dss_pkg::ST_WR_RELEASE:
         begin
            want      = 1'b1;
            want_addr = dss_pkg::ADDR_DCLK_RANGE;
            want_data = s_q.range;
            want_data[dss_pkg::RESTART_BIT] = 1'b0; // RL5
            want_nxt  = dss_pkg::ST_POLL_RD;
         end
         dss_pkg::ST_POLL_RD:
         begin
            want      = 1'b1;
            want_rd   = 1'b1;
            want_addr = dss_pkg::ADDR_LOCK_STATUS;
            want_nxt  = sif_rsp.rdata[dss_pkg::LOCK_BIT] ? dss_pkg::ST_SYNC_ON
                                                          : dss_pkg::ST_POLL_GAP; // RL6
            if (s_q.sent && sif_rsp.done && sif_rsp.rdata[dss_pkg::LOCK_BIT])
            begin
               s_d.locked      = 1'b1;
               ev[dss_pkg::IRQ_LOCK] = 1'b1;
            end
         end
         dss_pkg::ST_POLL_GAP:
         begin
            s_d.cnt = s_q.cnt + 16'h0001;
            if (s_q.cnt == POLL_GAP_CYC)
               s_d.st = dss_pkg::ST_POLL_RD; // RL6
         end
         dss_pkg::ST_SYNC_ON:
         begin
            if (s_q.use_sw)
            begin
               want      = 1'b1;
               want_addr = dss_pkg::ADDR_SYNC_CFG;
               want_data = sync_wr;
               want_data[dss_pkg::SOFTWARE_SYNC_BIT_BIT] = 1'b1; // RL8
               want_nxt  = dss_pkg::ST_STREAM;
               if (s_q.sent && sif_rsp.done)
               begin
                  s_d.done = 1'b1; // RL12
                  ev[dss_pkg::IRQ_DONE] = 1'b1;
               end
            end
            else if (dclk_upd)
            begin
               // sync rises together with the first sample
               s_d.sync_pin = 1'b1; // RL11
               s_d.data     = s_q.sample;
               s_d.done     = 1'b1; // RL12
               s_d.st       = dss_pkg::ST_STREAM;
               ev[dss_pkg::IRQ_DONE] = 1'b1;
            end
         end
         dss_pkg::ST_STREAM:
         begin
            if (dclk_upd)
               s_d.data = s_q.sample; // RL10
            if (!s_q.run)
            begin
               s_d.sync_pin = 1'b0; // RL9
               s_d.data     = '0;
               s_d.st       = dss_pkg::ST_STOP;
               ev[dss_pkg::IRQ_STOP] = 1'b1;
            end
         end
         dss_pkg::ST_STOP:
         begin
            s_d.done = 1'b0;
            if (s_q.use_sw)
            begin
               want      = 1'b1;
               want_addr = dss_pkg::ADDR_SYNC_CFG;
               want_data = sync_wr;
               want_data[dss_pkg::SOFTWARE_SYNC_BIT_BIT] = 1'b0; // RL9
               want_nxt  = dss_pkg::ST_IDLE;
            end
            else
            begin
               s_d.st = dss_pkg::ST_IDLE;
            end
         end
         default:
         begin
            s_d.st = dss_pkg::ST_IDLE;
         end
      endcase

      // one serial transaction per state: issue once, move on when it completes
      if (want)
      begin
         if (!s_q.sent)
         begin
            sif_req.go    = !sif_rsp.busy;
            sif_req.rd    = want_rd;
            sif_req.addr  = want_addr;
            sif_req.wdata = want_data;
            s_d.sent      = !sif_rsp.busy;
         end
         else if (sif_rsp.done)
         begin
            s_d.sent = 1'b0;
            s_d.st   = want_nxt;
            s_d.cnt  = '0;
         end
      end

      // sticky status: a new event wins over a clear in the same cycle
      if (wr && addr == dss_pkg::REG_IRQ_STAT)
         s_d.irq_stat = s_q.irq_stat & ~wdata[dss_pkg::IRQ_W-1:0];
      s_d.irq_stat = s_d.irq_stat | ev;

      // read data stand only in the cycle after the strobe
      s_d.rdata = '0;
      if (rd)
      begin
         case (addr)
            dss_pkg::REG_CTRL:
               s_d.rdata = 32'({s_q.run, s_q.software_sync_bit, 1'b0});
            dss_pkg::REG_RANGE:    s_d.rdata = 32'(s_q.range);
            dss_pkg::REG_STATUS:
               s_d.rdata = 32'({s_q.sync_pin, s_q.done, s_q.locked, s_q.st});
            dss_pkg::REG_IRQ_STAT: s_d.rdata = 32'(s_q.irq_stat);
            dss_pkg::REG_IRQ_MASK: s_d.rdata = 32'(s_q.irq_mask);
            dss_pkg::REG_SAMPLE:   s_d.rdata = 32'(s_q.sample);
            dss_pkg::REG_SYNC_CFG: s_d.rdata = 32'(s_q.sync_cfg);
            default:               s_d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         s_q         <= '0;
         s_q.st      <= dss_pkg::ST_IDLE;
         s_q.rst_pin <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign rdata           = s_q.rdata;
   assign irq             = |(s_q.irq_stat & s_q.irq_mask);
   assign reset_n_pin     = s_q.rst_pin;
   assign lvds_sync_input = s_q.sync_pin;
   assign lvds_data       = s_q.data; // RL12
   assign sif_sclk        = sif_pins.sclk;
   assign sif_sden_n      = sif_pins.sden_n;
   assign sif_sdio_o      = sif_pins.sdio_o;
   assign sif_sdio_oe     = sif_pins.sdio_oe;

endmodule

// *** dss_host_monitor.sv ***
`timescale 1ns/1ps
module dss_host_monitor (
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst_n,
   // device pins
   input wire logic        reset_n_pin,
   input wire logic        lvds_data_clock,
   input wire logic        lvds_sync_input,
   input wire logic [15:0] lvds_data,
   // serial pins
   input wire logic        sif_sclk,
   input wire logic        sif_sden_n,
   input wire logic        sif_sdio_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ****************
   // start-up order and data timing
   // ****************
   rst_pulse_a:
   assert property ($fell(reset_n_pin) |-> !reset_n_pin[*4] ##1 reset_n_pin)
      else $error("device reset pulse not four cycles");
   rst_quiet_a:
   assert property (!reset_n_pin |-> sif_sden_n)
      else $error("serial frame during device reset");
   rst_wait_a:
   assert property ($rose(reset_n_pin) |-> sif_sden_n[*8])
      else $error("serial frame too soon after reset");
   frame_oe_a:
   assert property ($fell(sif_sden_n) |-> sif_sdio_oe)
      else $error("frame opened without driving data");
   sclk_start_a:
   assert property ($fell(sif_sden_n) |-> !sif_sclk[*3] ##[1:2] sif_sclk)
      else $error("serial clock start wrong");
   dclk_low_a:
   assert property ($fell(lvds_data_clock) |-> !lvds_data_clock[*4])
      else $error("data clock low phase short");
   idle_data_a:
   assert property (!reset_n_pin |-> lvds_data == 16'h0000 && !lvds_sync_input)
      else $error("data or sync active during reset");
   sync_edge_a:
   assert property ($rose(lvds_sync_input) |-> $fell(lvds_data_clock))
      else $error("sync rose off the data clock fall");
   data_hold_a:
   assert property (lvds_sync_input && !$fell(lvds_data_clock) |-> $stable(lvds_data))
      else $error("sample changed between data clock falls");
endmodule

bind dss_host dss_host_monitor i_dss_host_monitor (
   .mclk(mclk), .rst_n(rst_n), .reset_n_pin(reset_n_pin),
   .lvds_data_clock(lvds_data_clock), .lvds_sync_input(lvds_sync_input),
   .lvds_data(lvds_data), .sif_sclk(sif_sclk), .sif_sden_n(sif_sden_n),
   .sif_sdio_oe(sif_sdio_oe)
);

// *** dss_host_tb.sv ***
`timescale 1ns/1ps
module dss_host_tb;
   logic        mclk = 1'h0;
   logic        rst_n = 1'h0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'h0;
   logic        rd = 1'h0;
   logic [31:0] rdata, v;
   logic [15:0] data, sample;
   logic        irq, rstp, dclk, sync, sclk, sden_n, serial_out_pin, soe, dev_sdo, passing;
   int          fails = 0, n_checks = 0, cyc = 0;
   wire         sdio = soe ? serial_out_pin : dev_sdo;
   always #4 mclk = ~mclk;
   dss_host #(.DCLK_SETTLE_CYC(16'h0010), .POLL_GAP_CYC(16'h0004)) i_dss_host (
      .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .irq(irq), .reset_n_pin(rstp), .lvds_data_clock(dclk),
      .lvds_sync_input(sync), .lvds_data(data), .sif_sclk(sclk),
      .sif_sden_n(sden_n), .sif_sdio_o(serial_out_pin), .sif_sdio_oe(soe), .sif_sdio_i(sdio));
   dss_dev_model i_dss_dev_model (
      .reset_n_pin(rstp), .lvds_data_clock(dclk), .lvds_sync_input(sync),
      .lvds_data(data), .sif_sclk(sclk), .sif_sden_n(sden_n), .sif_sdio_o(serial_out_pin),
      .serial_out_pin(dev_sdo), .passing(passing), .sample(sample));
   // ****************
   // bus and compare tasks
   // ****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge mclk);
      wr <= 1'h0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge mclk);
      addr <= a;
      rd <= 1'h1;
      @(posedge mclk);
      rd <= 1'h0;
      #1 v = rdata;
   endtask
   task automatic wait_st(input logic [31:0] m, input logic [31:0] e);
      v = ~e;
      for (int i = 0; i < 800 && (v & m) !== e; i++)
         rd_reg(dss_pkg::REG_STATUS);
      chk(v & m, e);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_reset;
      chk(32'({rstp, dclk, sync, sden_n, soe, irq, data}), 32'h240000);
      wr_reg(8'hFC, 32'hFFFFFFFF);
      rd_reg(8'hFC);
      chk(v, 32'h0);
      rd_reg(dss_pkg::REG_STATUS);
      chk(v, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_pin;
      wr_reg(dss_pkg::REG_RANGE, 32'h5A);
      wr_reg(dss_pkg::REG_SAMPLE, 32'hA5C3);
      wr_reg(dss_pkg::REG_SYNC_CFG, 32'h0);
      wr_reg(dss_pkg::REG_IRQ_MASK, 32'h7);
      wr_reg(dss_pkg::REG_CTRL, 32'h5);
      wr_reg(dss_pkg::REG_CTRL, 32'h5);
      wait_st(32'h30, 32'h30);
      chk(32'(i_dss_dev_model.polls > 1), 32'h1);
      chk(32'(i_dss_dev_model.rel_ok), 32'h1);
      chk(32'({i_dss_dev_model.regs[10], i_dss_dev_model.regs[14],
               i_dss_dev_model.regs[3]}), 32'h5A0100);
      repeat (16) @(posedge mclk);
      #1 chk(32'({sync, passing, irq, sample}), 32'h7A5C3);
      rd_reg(dss_pkg::REG_IRQ_STAT);
      chk(v, 32'h3);
      wr_reg(dss_pkg::REG_IRQ_MASK, 32'h0);
      #1 chk(32'(irq), 32'h0);
      wr_reg(dss_pkg::REG_IRQ_STAT, 32'h3);
      wr_reg(dss_pkg::REG_CTRL, 32'h0);
      wait_st(32'hF, 32'h0);
      chk(32'({sync, passing, data}), 32'h0);
      rd_reg(dss_pkg::REG_IRQ_STAT);
      chk(v, 32'h4);
      $display("test pin sync done");
   endtask
   task automatic t_sw;
      wr_reg(dss_pkg::REG_IRQ_STAT, 32'h7);
      wr_reg(dss_pkg::REG_RANGE, 32'h23);
      wr_reg(dss_pkg::REG_IRQ_MASK, 32'h4);
      wr_reg(dss_pkg::REG_CTRL, 32'h7);
      wait_st(32'h30, 32'h30);
      repeat (16) @(posedge mclk);
      #1 chk(32'({i_dss_dev_model.regs[10], i_dss_dev_model.regs[3],
                  sync, passing, irq}), 32'h1181A);
      rd_reg(dss_pkg::REG_CTRL);
      chk(v, 32'h6);
      wr_reg(dss_pkg::REG_CTRL, 32'h0);
      wait_st(32'hF, 32'h0);
      #1 chk(32'({i_dss_dev_model.regs[3], passing, irq}), 32'h9);
      $display("test software sync done");
   endtask
   // ****************
   // run control
   // ****************
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         test_done();
      end
   end
   initial
   begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'h1;
      t_reset();
      t_pin();
      t_sw();
      test_done();
   end
endmodule

// *** dss_pkg.sv ***
package dss_pkg;

   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int         CLK_PERIOD_PS   = 8000;
   localparam int         RST_LOW_NS      = 25;
   // least time: round up to whole clock cycles
   localparam logic [7:0] RST_LOW_CYC     =
      8'((RST_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] RST_RECOVER_CYC = 8'h10;
   localparam logic [7:0] DCLK_HALF_CYC   = 8'h04;
   localparam logic [7:0] SIF_HALF_CYC    = 8'h04;
   localparam logic [4:0] SIF_FRAME_BITS  = 5'h10;
   localparam logic [4:0] SIF_INSTR_BITS  = 5'h08;

   // ***********************************************************
   // device register map (reached over the serial interface)
   // ***********************************************************
   localparam logic [6:0] ADDR_LOCK_STATUS = 7'h00;
   localparam logic [6:0] ADDR_SYNC_CFG    = 7'h03;
   localparam logic [6:0] ADDR_DCLK_RANGE  = 7'h0A;
   localparam logic [6:0] ADDR_SOUT_CFG    = 7'h0E;
   localparam int         RESTART_BIT      = 7;
   localparam int         LOCK_BIT         = 0;
   localparam int         SOFTWARE_SYNC_BIT_BIT      = 0;
   localparam int         SYNC_SEL_BIT     = 1;
   localparam logic [7:0] SOUT_FUNC_LOCK   = 8'h01;

   // ***********************************************************
   // host register map
   // ***********************************************************
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_RANGE    = 8'h04;
   localparam logic [7:0] REG_STATUS   = 8'h08;
   localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
   localparam logic [7:0] REG_IRQ_MASK = 8'h10;
   localparam logic [7:0] REG_SAMPLE   = 8'h14;
   localparam logic [7:0] REG_SYNC_CFG = 8'h18;
   localparam int         CTRL_START   = 0;
   localparam int         CTRL_SOFTWARE_SYNC_BIT = 1;
   localparam int         CTRL_RUN     = 2;
   localparam int         IRQ_LOCK     = 0;
   localparam int         IRQ_DONE     = 1;
   localparam int         IRQ_STOP     = 2;
   localparam int         IRQ_W        = 3;

   typedef enum logic [3:0] {
      ST_IDLE, ST_RST_LOW, ST_RST_WAIT, ST_WR_RANGE, ST_WR_SOUT, ST_WR_SYNC,
      ST_DCLK_SETTLE, ST_WR_RELEASE, ST_POLL_RD, ST_POLL_GAP, ST_SYNC_ON,
      ST_STREAM, ST_STOP
   } dss_state_t;

   typedef struct packed {
      logic       go;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } dss_sif_req_t;

   typedef struct packed {
      logic       busy;
      logic       done;
      logic [7:0] rdata;
   } dss_sif_rsp_t;

   typedef struct packed {
      logic sclk;
      logic sden_n;
      logic sdio_o;
      logic sdio_oe;
   } dss_sif_pins_t;

endpackage

// *** dss_sif.sv ***
`timescale 1ns/1ps
module dss_sif (
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   // request and answer
   input  wire dss_pkg::dss_sif_req_t req,
   output dss_pkg::dss_sif_rsp_t      rsp,
   // serial pins
   output dss_pkg::dss_sif_pins_t     pins,
   input  wire logic                  sdio_i
);

   typedef struct packed {
      logic        act;
      logic        rd;
      logic        done;
      logic [4:0]  bitn;
      logic [7:0]  half;
      logic [15:0] shreg;
      logic [7:0]  rdata;
      logic        sclk;
      logic        meta;
      logic        sdi;
   } dss_sif_st_t;

   dss_sif_st_t s_q;
   dss_sif_st_t s_d;

   always_comb
   begin
      s_d      = s_q;
      s_d.done = 1'b0;
      s_d.meta = sdio_i;
      s_d.sdi  = s_q.meta;
      if (!s_q.act)
      begin
         if (req.go)
         begin
            s_d.act   = 1'b1;
            s_d.rd    = req.rd;
            s_d.bitn  = '0;
            s_d.half  = '0;
            s_d.shreg = {req.rd, req.addr, req.wdata};
         end
      end
      else if (s_q.half == dss_pkg::SIF_HALF_CYC - 8'h01)
      begin
         s_d.half = '0;
         s_d.sclk = !s_q.sclk;
         if (!s_q.sclk)
         begin
            // rising edge: the device samples, and read data are taken here
            s_d.rdata = {s_q.rdata[6:0], s_q.sdi};
         end
         else
         begin
            s_d.shreg = {s_q.shreg[14:0], 1'b0};
            s_d.bitn  = s_q.bitn + 5'h01;
            if (s_q.bitn == dss_pkg::SIF_FRAME_BITS - 5'h01)
            begin
               s_d.act  = 1'b0;
               s_d.done = 1'b1;
            end
         end
      end
      else
      begin
         s_d.half = s_q.half + 8'h01;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // pin released after the instruction byte of a read so the device may drive it
   assign pins.sclk    = s_q.sclk;
   assign pins.sden_n  = !s_q.act;
   assign pins.sdio_o  = s_q.shreg[15];
   assign pins.sdio_oe = s_q.act && !(s_q.rd && s_q.bitn >= dss_pkg::SIF_INSTR_BITS);
   // busy comes from the register only: the caller derives its go from it
   assign rsp.busy     = s_q.act;
   assign rsp.done     = s_q.done;
   assign rsp.rdata    = s_q.rdata;

endmodule
